// ==== rtl/fmsp_pkg.sv ====
// Constants and state encodings shared by the four-mode serial port.
// Assumes a 32-bit Avalon-MM register bus with one register per aligned word.
package fmsp_pkg;

   // Register byte addresses on the bus.
   localparam logic [7:0] CTRL_OFS = 8'h98;
   localparam logic [7:0] BUF_OFS  = 8'h9C;
   localparam logic [7:0] PWR_OFS  = 8'hA0;

   // Values after reset.
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] PWR_RST  = 8'h00;

   // Field positions in the power control register.
   localparam int PWR_RATE_BIT = 7;
   localparam int PWR_VIEW_BIT = 6;

   // Shift-register mode timing: one bit per six clocks, clock low for the first three.
   localparam logic [3:0] M0_LAST = 4'h5;
   localparam logic [3:0] M0_HALF = 4'h3;
   localparam logic [3:0] M0_BITS = 4'h8;

   // Asynchronous modes: sixteen ticks per bit, sampled in the middle tick.
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_MID  = 4'h7;

   // Index of the stop bit within a frame, start bit being index zero.
   localparam logic [3:0] STOP_IDX_8 = 4'h9;
   localparam logic [3:0] STOP_IDX_9 = 4'hA;

   // Serial port modes as held in the two mode-select bits.
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_8BIT  = 2'h1;
   localparam logic [1:0] MODE_9FIX  = 2'h2;
   localparam logic [1:0] MODE_9VAR  = 2'h3;

   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_ASYNC} fmsp_tx_st_t;
   typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_ASYNC} fmsp_rx_st_t;

endpackage

// ==== rtl/fmsp_serial_port.sv ====
// Four-mode serial port: shift-register mode and three asynchronous modes.
// Assumes synchronous pin inputs, one clock, and an Avalon-MM master.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module fmsp_serial_port #(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input  wire logic              sys_clk_i,
   input  wire logic              resetn_i,
   // Avalon-MM register slave.
   input  wire logic [ADDR_W-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic      [31:0]       avs_readdata_o,
   output logic                   avs_waitrequest_o,
   // Bit-rate source for the variable-rate modes.
   input  wire logic              timer1_ovf_i,
   // Serial pins; the receive pin turns around in shift-register mode.
   input  wire logic              rxd_i,
   output logic                   rxd_o,
   output logic                   rxd_oe_n_o,
   output logic                   txd_o
);

   if (ADDR_W < 8) begin : g_addr_chk
      $error("fmsp_serial_port: ADDR_W must be at least 8");
   end

   // Whole state of the port in one record.
   typedef struct packed {
      logic                 mode_select_high;
      logic                 mode_select_low;
      logic                 multiprocessor_enable;
      logic                 receive_enable;
      logic                 transmit_ninth_bit;
      logic                 received_ninth_bit;
      logic                 transmit_done_flag;
      logic                 receive_done_flag;
      logic                 framing_error_flag;
      logic                 bit7_view_select;
      logic                 rate_double_select;
      logic [7:0]           rx_buf;
      logic                 div;
      fmsp_pkg::fmsp_tx_st_t tx_st;
      logic [10:0]          tx_sh;
      logic [3:0]           tx_cnt;
      logic [3:0]           tx_ph;
      fmsp_pkg::fmsp_rx_st_t rx_st;
      logic [8:0]           rx_sh;
      logic [3:0]           rx_cnt;
      logic [3:0]           rx_ph;
      logic                 rx_prev;
      logic                 ack;
      logic [31:0]          rdata;
      logic                 txd;
      logic                 rxd_out;
      logic                 rxd_oe_n;
   } fmsp_state_t;

   fmsp_state_t s_q;
   fmsp_state_t s_d;

   logic [1:0] mode;
   logic       req;
   logic       wr_go;
   logic       tx_start;
   logic       tick16;
   logic [3:0] stop_idx;
   logic       stop_bit;
   logic       nine_bit;
   logic [7:0] rx_data;
   logic [7:0] ctrl_view;
   logic [7:0] addr8;

   // Bus decode. A request waits exactly one cycle, so read data are registered.
   assign addr8     = avs_address_i[7:0];
   assign mode      = {s_q.mode_select_high, s_q.mode_select_low};
   assign req       = avs_read_i | avs_write_i;
   assign wr_go     = avs_write_i & s_q.ack & avs_byteenable_i[0];
   assign tx_start  = wr_go & (addr8 == fmsp_pkg::BUF_OFS);
   assign avs_waitrequest_o = req & ~s_q.ack;
   assign avs_readdata_o    = s_q.rdata;

   // Bit 7 of the control register is a shared view.
   assign ctrl_view = {s_q.bit7_view_select ? s_q.framing_error_flag
                                            : s_q.mode_select_high,
                       s_q.mode_select_low, s_q.multiprocessor_enable,
                       s_q.receive_enable, s_q.transmit_ninth_bit,
                       s_q.received_ninth_bit, s_q.transmit_done_flag,
                       s_q.receive_done_flag};

   // Sixteen-times tick: every clock or every other one in mode 2, and every
   // or every other timer overflow in modes 1 and 3.
   assign tick16 = (mode == fmsp_pkg::MODE_9FIX)
                 ? (s_q.rate_double_select | s_q.div)
                 : (timer1_ovf_i & (s_q.rate_double_select | s_q.div));

   // The frame of mode 1 is one bit shorter than the nine-bit frames.
   assign stop_idx = (mode == fmsp_pkg::MODE_8BIT) ? fmsp_pkg::STOP_IDX_8
                                                   : fmsp_pkg::STOP_IDX_9;

   // Received fields; in mode 1 the stop bit stands in for the ninth bit.
   assign stop_bit = rxd_i;
   assign nine_bit = (mode == fmsp_pkg::MODE_8BIT) ? stop_bit : s_q.rx_sh[8];
   assign rx_data  = (mode == fmsp_pkg::MODE_8BIT) ? s_q.rx_sh[8:1] : s_q.rx_sh[7:0];

   // Next-state logic. Software writes come first so that hardware sets win.
   always_comb begin
      s_d     = s_q;
      s_d.ack = req & ~s_q.ack;
      s_d.rx_prev = rxd_i;

      // Rate divider used for the halved bit rates.
      if (mode == fmsp_pkg::MODE_9FIX) begin
         s_d.div = ~s_q.div;
      end else if (timer1_ovf_i) begin
         s_d.div = ~s_q.div;
      end

      // Read data are captured in the waiting cycle; unmapped reads give zero.
      if (req & ~s_q.ack) begin
         s_d.rdata = 32'h0000_0000;
         if (avs_read_i) begin
            unique case (addr8)
               fmsp_pkg::CTRL_OFS: s_d.rdata[7:0] = ctrl_view;
               fmsp_pkg::BUF_OFS:  s_d.rdata[7:0] = s_q.rx_buf;
               fmsp_pkg::PWR_OFS: begin
                  s_d.rdata[fmsp_pkg::PWR_RATE_BIT] = s_q.rate_double_select;
                  s_d.rdata[fmsp_pkg::PWR_VIEW_BIT] = s_q.bit7_view_select;
               end
               default: s_d.rdata = 32'h0000_0000;
            endcase
         end
      end

      // Software writes to control and power registers.
      if (wr_go && addr8 == fmsp_pkg::CTRL_OFS) begin
         if (s_q.bit7_view_select) begin
            s_d.framing_error_flag = avs_writedata_i[7];
         end else begin
            s_d.mode_select_high = avs_writedata_i[7];
         end
         s_d.mode_select_low       = avs_writedata_i[6];
         s_d.multiprocessor_enable = avs_writedata_i[5];
         s_d.receive_enable        = avs_writedata_i[4];
         s_d.transmit_ninth_bit    = avs_writedata_i[3];
         s_d.received_ninth_bit    = avs_writedata_i[2];
         s_d.transmit_done_flag    = avs_writedata_i[1];
         s_d.receive_done_flag     = avs_writedata_i[0];
      end
      if (wr_go && addr8 == fmsp_pkg::PWR_OFS) begin
         s_d.rate_double_select = avs_writedata_i[fmsp_pkg::PWR_RATE_BIT];
         s_d.bit7_view_select   = avs_writedata_i[fmsp_pkg::PWR_VIEW_BIT];
      end

      // Transmit engine, independent of the receiver.
      unique case (s_q.tx_st)
         fmsp_pkg::TX_IDLE: begin
         end
         fmsp_pkg::TX_SHIFT: begin
            s_d.tx_ph = s_q.tx_ph + 4'h1;
            if (s_q.tx_ph == fmsp_pkg::M0_LAST) begin
               s_d.tx_ph  = 4'h0;
               s_d.tx_sh  = {1'b1, s_q.tx_sh[10:1]};
               s_d.tx_cnt = s_q.tx_cnt + 4'h1;
               if (s_q.tx_cnt == fmsp_pkg::M0_BITS - 4'h1) begin
                  s_d.transmit_done_flag = 1'b1;
                  s_d.tx_st = fmsp_pkg::TX_IDLE;
               end
            end
         end
         fmsp_pkg::TX_ASYNC: begin
            if (tick16) begin
               s_d.tx_ph = s_q.tx_ph + 4'h1;
               if (s_q.tx_ph == fmsp_pkg::OVS_LAST) begin
                  if (s_q.tx_cnt == stop_idx) begin
                     s_d.tx_st = fmsp_pkg::TX_IDLE;
                  end else begin
                     s_d.tx_sh  = {1'b1, s_q.tx_sh[10:1]};
                     s_d.tx_cnt = s_q.tx_cnt + 4'h1;
                     if (s_q.tx_cnt + 4'h1 == stop_idx) begin
                        s_d.transmit_done_flag = 1'b1;
                     end
                  end
               end
            end
         end
         default: s_d.tx_st = fmsp_pkg::TX_IDLE;
      endcase

      // A buffer write restarts the transmitter, even mid-frame.
      if (tx_start) begin
         s_d.tx_ph  = 4'h0;
         s_d.tx_cnt = 4'h0;
         if (mode == fmsp_pkg::MODE_SHIFT) begin
            s_d.tx_st = fmsp_pkg::TX_SHIFT;
            s_d.tx_sh = {3'h7, avs_writedata_i[7:0]};
         end else begin
            s_d.tx_st = fmsp_pkg::TX_ASYNC;
            // Start bit low, data LSB first, ninth bit, stop bit high.
            s_d.tx_sh = {1'b1,
                         (mode == fmsp_pkg::MODE_8BIT) ? 1'b1 : s_q.transmit_ninth_bit,
                         avs_writedata_i[7:0], 1'b0};
         end
      end

      // Receive engine.
      unique case (s_q.rx_st)
         fmsp_pkg::RX_IDLE: begin
            s_d.rx_ph  = 4'h0;
            s_d.rx_cnt = 4'h0;
            if (mode == fmsp_pkg::MODE_SHIFT) begin
               // The shift clock is shared, so a running transmit blocks reception.
               if (s_q.receive_enable && !s_q.receive_done_flag &&
                   s_q.tx_st == fmsp_pkg::TX_IDLE && !tx_start) begin
                  s_d.rx_st = fmsp_pkg::RX_SHIFT;
               end
            end else if (s_q.receive_enable && s_q.rx_prev && !rxd_i) begin
               s_d.rx_st = fmsp_pkg::RX_ASYNC;
            end
         end
         fmsp_pkg::RX_SHIFT: begin
            s_d.rx_ph = s_q.rx_ph + 4'h1;
            if (s_q.rx_ph == fmsp_pkg::M0_HALF) begin
               s_d.rx_sh  = {rxd_i, s_q.rx_sh[8:1]};
               s_d.rx_cnt = s_q.rx_cnt + 4'h1;
            end
            if (s_q.rx_ph == fmsp_pkg::M0_LAST) begin
               s_d.rx_ph = 4'h0;
               if (s_q.rx_cnt == fmsp_pkg::M0_BITS) begin
                  s_d.rx_buf = s_q.rx_sh[8:1];
                  s_d.receive_done_flag = 1'b1;
                  s_d.rx_st = fmsp_pkg::RX_IDLE;
               end
            end
            if (tx_start) begin
               s_d.rx_st = fmsp_pkg::RX_IDLE;
            end
         end
         fmsp_pkg::RX_ASYNC: begin
            if (tick16) begin
               s_d.rx_ph = s_q.rx_ph + 4'h1;
               if (s_q.rx_ph == fmsp_pkg::OVS_MID) begin
                  if (s_q.rx_cnt == 4'h0) begin
                     // A start bit that is gone by mid-bit was a glitch.
                     if (rxd_i) begin
                        s_d.rx_st = fmsp_pkg::RX_IDLE;
                     end
                     s_d.rx_cnt = 4'h1;
                  end else if (s_q.rx_cnt == stop_idx) begin
                     if (!stop_bit) begin
                        s_d.framing_error_flag = 1'b1;
                     end
                     // A newer character overwrites an unread one.
                     if (!s_q.multiprocessor_enable || nine_bit) begin
                        s_d.rx_buf             = rx_data;
                        s_d.received_ninth_bit = nine_bit;
                        s_d.receive_done_flag  = 1'b1;
                     end
                     s_d.rx_st = fmsp_pkg::RX_IDLE;
                  end else begin
                     s_d.rx_sh  = {rxd_i, s_q.rx_sh[8:1]};
                     s_d.rx_cnt = s_q.rx_cnt + 4'h1;
                  end
               end
            end
         end
         default: s_d.rx_st = fmsp_pkg::RX_IDLE;
      endcase

      // Pin drive, registered. Mode 0 clock is low for three clocks, high for three.
      s_d.rxd_out  = s_d.tx_sh[0];
      s_d.rxd_oe_n = (s_d.tx_st != fmsp_pkg::TX_SHIFT);
      if (s_d.tx_st == fmsp_pkg::TX_SHIFT) begin
         s_d.txd = (s_d.tx_ph >= fmsp_pkg::M0_HALF);
      end else if (s_d.rx_st == fmsp_pkg::RX_SHIFT) begin
         s_d.txd = (s_d.rx_ph >= fmsp_pkg::M0_HALF);
      end else if (s_d.tx_st == fmsp_pkg::TX_ASYNC) begin
         s_d.txd = s_d.tx_sh[0];
      end else begin
         s_d.txd = 1'b1;
      end
   end

   // State register; the line idles high and the receive pin is released.
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q                       <= '0;
         {s_q.mode_select_high, s_q.mode_select_low, s_q.multiprocessor_enable,
          s_q.receive_enable, s_q.transmit_ninth_bit, s_q.received_ninth_bit,
          s_q.transmit_done_flag, s_q.receive_done_flag} <= fmsp_pkg::CTRL_RST;
         s_q.rate_double_select    <= fmsp_pkg::PWR_RST[fmsp_pkg::PWR_RATE_BIT];
         s_q.bit7_view_select      <= fmsp_pkg::PWR_RST[fmsp_pkg::PWR_VIEW_BIT];
         s_q.tx_st                 <= fmsp_pkg::TX_IDLE;
         s_q.rx_st                 <= fmsp_pkg::RX_IDLE;
         s_q.tx_sh                 <= 11'h7FF;
         s_q.rx_prev               <= 1'b1;
         s_q.txd                   <= 1'b1;
         s_q.rxd_out               <= 1'b1;
         s_q.rxd_oe_n              <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Pin outputs straight from flip-flops.
   assign txd_o      = s_q.txd;
   assign rxd_o      = s_q.rxd_out;
   assign rxd_oe_n_o = s_q.rxd_oe_n;

endmodule

`default_nettype wire

// ==== bench/fmsp_serial_port_asserts.sv ====
// Checker for the serial port's bus handshake and pin timing.
// Assumes it is bound onto fmsp_serial_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fmsp_serial_port_asserts #(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input wire logic              sys_clk_i,
   input wire logic              resetn_i,
   // Register bus.
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic              avs_read_i,
   input wire logic              avs_write_i,
   input wire logic [3:0]        avs_byteenable_i,
   input wire logic [31:0]       avs_writedata_i,
   input wire logic [31:0]       avs_readdata_o,
   input wire logic              avs_waitrequest_o,
   // Serial pins.
   input wire logic              rxd_oe_n_o,
   input wire logic              rxd_o,
   input wire logic              txd_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   logic       req;
   logic [7:0] low_q;
   logic       wr_ok;
   logic       view_q;
   logic [1:0] mode_q;
   assign req = avs_read_i || avs_write_i;
   assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   // Mirrors the mode bits from bus writes, since the shift clock and an
   // async frame look alike on the transmit pin.
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         view_q <= fmsp_pkg::PWR_RST[fmsp_pkg::PWR_VIEW_BIT];
         mode_q <= fmsp_pkg::CTRL_RST[7:6];
      end else if (wr_ok && avs_address_i[7:0] == fmsp_pkg::PWR_OFS) begin
         view_q <= avs_writedata_i[fmsp_pkg::PWR_VIEW_BIT];
      end else if (wr_ok && avs_address_i[7:0] == fmsp_pkg::CTRL_OFS) begin
         mode_q <= {view_q ? mode_q[1] : avs_writedata_i[7], avs_writedata_i[6]};
      end
   end
   // Counts driven cycles of the receive pin, so a cut-short shift frame shows.
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i)
         low_q <= 8'h00;
      else if (rxd_oe_n_o)
         low_q <= 8'h00;
      else
         low_q <= low_q + 8'h01;
   end
   property p_wait_first;
      req && !$past(req) |-> avs_waitrequest_o;
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("No wait cycle.");
   property p_wait_one;
      req && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("Wait too long.");
   property p_idle;
      !req |-> !avs_waitrequest_o;
   endproperty
   a_idle: assert property (p_idle) else $error("Wait while idle.");
   property p_upper;
      avs_readdata_o[31:8] == 24'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("Upper data set.");
   property p_hold;
      !req |=> $stable(avs_readdata_o);
   endproperty
   a_hold: assert property (p_hold) else $error("Read data moved.");
   property p_start;
      avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
         && avs_address_i[7:0] == fmsp_pkg::BUF_OFS |-> ##[1:2] !txd_o;
   endproperty
   a_start: assert property (p_start) else $error("No transmit start.");
   property p_m0_clk;
      $fell(txd_o) && !rxd_oe_n_o |-> !txd_o [*3] ##1 txd_o [*3];
   endproperty
   a_m0_clk: assert property (p_m0_clk) else $error("Shift clock shape.");
   property p_m0_data;
      !rxd_oe_n_o && txd_o && $past(txd_o) |-> $stable(rxd_o);
   endproperty
   a_m0_data: assert property (p_m0_data) else $error("Shift data moved.");
   property p_m0_len;
      $rose(rxd_oe_n_o) |-> low_q == 8'h30;
   endproperty
   a_m0_len: assert property (p_m0_len) else $error("Shift frame length.");
   property p_async_bit;
      $fell(txd_o) && rxd_oe_n_o && mode_q != fmsp_pkg::MODE_SHIFT ##1 rxd_oe_n_o
         |-> !txd_o [*7];
   endproperty
   a_async_bit: assert property (p_async_bit) else $error("Bit too short.");
   property p_m0_rx_clk;
      $fell(txd_o) && rxd_oe_n_o && mode_q == fmsp_pkg::MODE_SHIFT |-> !txd_o [*3] ##1 txd_o [*3];
   endproperty
   a_m0_rx_clk: assert property (p_m0_rx_clk) else $error("Receive clock shape.");
endmodule
bind fmsp_serial_port fmsp_serial_port_asserts #(.ADDR_W(ADDR_W)) i_fmsp_serial_port_asserts (
   .sys_clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i,
   .avs_writedata_i,
   .avs_readdata_o, .avs_waitrequest_o, .rxd_oe_n_o, .rxd_o, .txd_o);
`default_nettype wire

// ==== bench/fmsp_remote.sv ====
// Remote sender driving the port's receive pin, free-running or on the shift clock.
// Assumes send is called right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module fmsp_remote (
   // Clock.
   input  wire logic sys_clk_i,
   // Shift clock from the port in shift-register mode.
   input  wire logic sclk_i,
   // Line toward the port; idles high like a real line.
   output logic      line_o
);
   initial line_o = 1'b1;
   // Sends n bits LSB first, each for per clocks, then returns to idle.
   task automatic send(input logic [10:0] f, input int n, input int per);
      for (int i = 0; i < n; i++) begin
         line_o <= f[i];
         repeat (per) @(posedge sys_clk_i);
      end
      line_o <= 1'b1;
   endtask
   // Shift-register partner: a bit goes out while the shift clock is low and
   // stands through the high phase, in which the port samples it.
   task automatic shift_out(input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         do begin
            @(posedge sys_clk_i);
         end while (sclk_i !== 1'b0);
         line_o <= d[i];
         do begin
            @(posedge sys_clk_i);
         end while (sclk_i !== 1'b1);
      end
      line_o <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== bench/four_mode_serial_port_test.sv ====
// Self-checking bench for the four-mode serial port.
// Assumes fmsp_remote as far-side sender and the checker bound in.
`timescale 1ns/1ps
`default_nettype none
module four_mode_serial_port_test;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        ovf = 1'b0;
   logic [31:0] rdata, q, rng = 32'h0000_003F;
   logic        waitreq, rxd_o, oe_n, txd, line, nine;
   logic [10:0] got;
   logic [1:0]  md_t [4] = '{2'h2, 2'h2, 2'h1, 2'h3};
   int          per_t [4] = '{16, 32, 32, 64};
   int          error_cnt = 0;
   int          compares = 0;
   int          cyc = 0;
   // The shared pin: the port drives it only while its enable is low.
   wire logic   rxd_pin = oe_n ? line : rxd_o;
   fmsp_serial_port i_fmsp_serial_port (.sys_clk_i(sys_clk), .resetn_i(resetn),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
      .timer1_ovf_i(ovf), .rxd_i(rxd_pin), .rxd_o(rxd_o), .rxd_oe_n_o(oe_n), .txd_o(txd));
   fmsp_remote i_fmsp_remote (.sys_clk_i(sys_clk), .sclk_i(txd), .line_o(line));
   always #10 sys_clk = ~sys_clk;
   // Overflow runs always, so the fixed-rate modes must ignore it.
   always @(posedge sys_clk) ovf <= ~ovf;
   // Cuts a hang short well past the few thousand cycles the run needs.
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Expected frame with start bit at index zero.
   function automatic logic [10:0] frm(input logic n9, input logic [7:0] d, input logic b9,
                                       input logic st);
      return n9 ? {st, b9, d, 1'b0} : {1'b1, st, d, 1'b0};
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // One bus cycle held until waitrequest is seen low at a rising edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= {24'h0, d};
      do begin
         @(posedge sys_clk);
      end while (waitreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // Samples a transmitted frame in the middle of each bit.
   task automatic grab(input int n, input int per);
      got = 11'h7FF;
      while (txd !== 1'b0) @(negedge sys_clk);
      repeat (per / 2) @(negedge sys_clk);
      for (int i = 0; i < n; i++) begin
         got[i] = txd;
         repeat (per) @(negedge sys_clk);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      bus(0, fmsp_pkg::CTRL_OFS, 8'h00);
      chk("control", 32'h0, q);
      bus(0, fmsp_pkg::PWR_OFS, 8'h00);
      chk("power", 32'h0, q);
      bus(0, 8'hA4, 8'h00);
      chk("unmapped", 32'h0, q);
      $display("test reset done");
      // Shift mode: data is stable on the pin while the clock is high.
      rng = xs(rng);
      bus(1, fmsp_pkg::BUF_OFS, rng[7:0]);
      for (int i = 0; i < 8; i++) begin
         while (txd !== 1'b0) @(negedge sys_clk);
         while (txd !== 1'b1) @(negedge sys_clk);
         got[i] = rxd_o;
      end
      // The done flag rises three clocks after the last bit is seen, with the pin release.
      while (oe_n !== 1'b1) @(negedge sys_clk);
      chk("shift data", {24'h0, rng[7:0]}, {24'h0, got[7:0]});
      bus(0, fmsp_pkg::CTRL_OFS, 8'h00);
      chk("control", 32'h2, q);
      $display("test shift mode done");
      // Each async setting sends and receives at once.
      for (int k = 0; k < 4; k++) begin
         rng = xs(rng);
         nine = md_t[k][1];
         bus(1, fmsp_pkg::PWR_OFS, k[0] ? 8'h00 : 8'h80);
         bus(1, fmsp_pkg::CTRL_OFS, {md_t[k], 2'b01, rng[8], 3'b000});
         bus(1, fmsp_pkg::BUF_OFS, rng[7:0]);
         fork
            grab(nine ? 11 : 10, per_t[k]);
            i_fmsp_remote.send(frm(nine, rng[23:16], rng[24], 1'b1), nine ? 11 : 10, per_t[k]);
         join
         chk("frame", {21'h0, frm(nine, rng[7:0], rng[8], 1'b1)}, {21'h0, got});
         bus(0, fmsp_pkg::BUF_OFS, 8'h00);
         chk("rx data", {24'h0, rng[23:16]}, q);
         bus(0, fmsp_pkg::CTRL_OFS, 8'h00);
         chk("control", {md_t[k], 2'b01, rng[8], nine ? rng[24] : 1'b1, 2'b11}, q);
      end
      $display("test async modes done");
      // Bad stop, then a good unread frame over the first.
      rng = xs(rng);
      bus(1, fmsp_pkg::CTRL_OFS, 8'h90);
      bus(1, fmsp_pkg::PWR_OFS, 8'hC0);
      i_fmsp_remote.send(frm(1'b1, rng[7:0], 1'b1, 1'b0), 11, 16);
      @(posedge sys_clk);
      i_fmsp_remote.send(frm(1'b1, rng[15:8], 1'b0, 1'b1), 11, 16);
      bus(0, fmsp_pkg::CTRL_OFS, 8'h00);
      chk("control", 32'h91, q);
      bus(0, fmsp_pkg::BUF_OFS, 8'h00);
      chk("rx data", {24'h0, rng[15:8]}, q);
      bus(1, fmsp_pkg::CTRL_OFS, 8'h10);
      bus(0, fmsp_pkg::CTRL_OFS, 8'h00);
      chk("control", 32'h10, q);
      bus(1, fmsp_pkg::PWR_OFS, 8'h80);
      bus(0, fmsp_pkg::CTRL_OFS, 8'h00);
      chk("control", 32'h90, q);
      $display("test framing done");
      // Address filter, then reception switched off.
      bus(1, fmsp_pkg::CTRL_OFS, 8'hB0);
      i_fmsp_remote.send(frm(1'b1, rng[31:24], 1'b0, 1'b1), 11, 16);
      bus(0, fmsp_pkg::CTRL_OFS, 8'h00);
      chk("control", 32'hB0, q);
      bus(1, fmsp_pkg::CTRL_OFS, 8'h80);
      i_fmsp_remote.send(frm(1'b1, rng[31:24], 1'b1, 1'b1), 11, 16);
      bus(0, fmsp_pkg::CTRL_OFS, 8'h00);
      chk("control", 32'h80, q);
      $display("test filter done");
      // Shift-mode reception, started by enable with the done flag clear.
      rng = xs(rng);
      bus(1, fmsp_pkg::CTRL_OFS, 8'h10);
      i_fmsp_remote.shift_out(rng[7:0]);
      do begin
         bus(0, fmsp_pkg::CTRL_OFS, 8'h00);
      end while (q[0] !== 1'b1);
      chk("control", 32'h11, q);
      bus(0, fmsp_pkg::BUF_OFS, 8'h00);
      chk("rx data", {24'h0, rng[7:0]}, q);
      $display("test shift receive done");
      conclude();
   end
endmodule
`default_nettype wire
